// ==== src/sacop_cfg.svh ====
// constants of the sar converter output port: widths, pins, timing, resets
`ifndef SACOP_CFG_SVH
`define SACOP_CFG_SVH

`define SACOP_RES_W          16
`define SACOP_FIFO_DEPTH     16
`define SACOP_CHAIN_BITS     16
`define SACOP_SERIAL_CHAIN_INPUT_BIT       9
`define SACOP_SERIAL_RESULT_OUTPUT_BIT      10
`define SACOP_SCLK_BIT       11
`define SACOP_SER_DRIVE_MASK 16'h0400
`define SACOP_DRIVE_ALL_N    16'h0000
`define SACOP_DRIVE_NONE_N   16'hffff
`define SACOP_MSB_MASK       16'h8000
`define SACOP_RESULT_RST     16'h0000
`define SACOP_SHIFT_RST      16'h0000
`define SACOP_IN_IDLE        10'h380
`define SACOP_CLK_MHZ        20
`define SACOP_CONV_TIME_NS   2500
`define SACOP_CONV_CYCLES    ((`SACOP_CONV_TIME_NS * `SACOP_CLK_MHZ) / 1000)
`define SACOP_CNT_W          6

`endif

// ==== src/sacop_pkg.sv ====
// shared types of the sar converter output port
`include "sacop_cfg.svh"
package sacop_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_PUSH = 2'b10
	} sacop_state_t;

	// pin levels that enter from outside the clock domain
	typedef struct packed {
		logic cnv_n;
		logic cs_n;
		logic rd_n;
		logic rst_pin;
		logic pd;
		logic ser;
		logic ob;
		logic swap;
		logic serial_chain_input;
		logic sclk;
	} sacop_in_t;

	// data pin drive: level and low-active output enable per line
	typedef struct packed {
		logic [`SACOP_RES_W-1:0] dout;
		logic [`SACOP_RES_W-1:0] oe_n;
	} sacop_pins_t;
endpackage

// ==== src/sacop_fifo.sv ====
// result fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sacop_fifo #(
	parameter int W     = 16, // word width
	parameter int DEPTH = 16  // words, power of two
) (
	input  wire logic         sys_clk,   // system clock
	input  wire logic         rst_n,     // async reset, low active
	input  wire logic         flush,     // drops all words
	input  wire logic         in_valid,  // word offered
	output logic              in_ready,  // room for a word
	input  wire logic [W-1:0] in_data,   // word in
	output logic              out_valid, // word waiting
	input  wire logic         out_ready, // drain takes word
	output logic [W-1:0]      out_data   // oldest word
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_reg  [DEPTH];
	logic [W-1:0] mem_next [DEPTH];
	logic [AW:0]  wr_reg;
	logic [AW:0]  wr_next;
	logic [AW:0]  rd_reg;
	logic [AW:0]  rd_next;
	logic         full;
	logic         empty;

	// extra pointer bit tells full from empty
	assign full      = (wr_reg[AW] != rd_reg[AW]) &&
	                   (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	assign empty     = (wr_reg == rd_reg);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem_reg[rd_reg[AW-1:0]];

	// pointer and storage update
	always_comb begin
		mem_next = mem_reg;
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		if (flush) begin
			wr_next = '0;
			rd_next = '0;
		end else begin
			if (in_valid && !full) begin
				mem_next[wr_reg[AW-1:0]] = in_data;
				wr_next = wr_reg + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_next = rd_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_reg <= '{default: '0};
			wr_reg  <= '0;
			rd_reg  <= '0;
		end else begin
			mem_reg <= mem_next;
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
		end
	end
endmodule
`default_nettype wire

// ==== src/sacop_top.sv ====
// sar converter control, result register and parallel/serial output port
`timescale 1ns/100ps
`default_nettype none
`include "sacop_cfg.svh"

// Notes on behaviour
// - serial select high picks the serial port, low picks the parallel port.
// - in serial mode every data line except the serial output floats.
// - format select high gives offset binary; low inverts msb for two's complement.
// - byte swap high exchanges the upper and lower result bytes on the parallel bus.
// - parallel mode drives the sixteen data lines with result bits 0 to 15.
// - serial mode uses lines 9, 10, 11 as chain in, data out, shift clock.
// - serial data leaves msb first, changing on rising shift clock edges.
// - chain input level reaches serial output sixteen shift clocks after read start.
// - busy rises at conversion start and falls once the result is available.
// - output drivers are on only while select and read strobe are both low.
// - the shift clock is ignored unless device select is low.
// - reset pin high aborts any conversion and floats the data bus.
// - power down high ignores conversion start requests.
// - falling start edge holds the sampler and begins conversion, select ignored.
module sacop_top #(
	parameter int FIFO_DEPTH = `SACOP_FIFO_DEPTH // results that may queue
) (
	input  wire logic                    sys_clk,                // 20 MHz
	input  wire logic                    rst_n,                  // async reset
	input  wire logic                    conversion_start_n,     // start edge
	input  wire logic                    device_select_n,        // chip select
	input  wire logic                    read_strobe_n,          // read enable
	input  wire logic                    reset_request,          // reset pin
	input  wire logic                    power_down_request,     // power down
	input  wire logic                    serial_parallel_select, // 1 serial
	input  wire logic                    output_format_select,   // 1 offset
	input  wire logic                    byte_order_swap,        // 1 swap
	input  wire logic [`SACOP_RES_W-1:0] parallel_data_bits_in,  // pin levels
	output var  sacop_pkg::sacop_pins_t  parallel_data_bits_drv, // pin drive
	input  wire logic [`SACOP_RES_W-1:0] sar_code,               // core code
	output logic                         busy,                   // converting
	output logic                         sampler_hold,           // hold mode
	output logic                         powered_down            // pd level
);
	import sacop_pkg::*;

	localparam int RW = `SACOP_RES_W;
	localparam logic [`SACOP_CNT_W-1:0] CONV_LAST =
		`SACOP_CNT_W'(`SACOP_CONV_CYCLES - 1);

	// msb inversion turns offset binary into two's complement
	function automatic logic [RW-1:0] fmt_code(input logic [RW-1:0] c,
	                                            input logic ob);
		fmt_code = ob ? c : (c ^ `SACOP_MSB_MASK);
	endfunction

	function automatic logic [RW-1:0] swap_bytes(input logic [RW-1:0] c,
	                                              input logic sw);
		swap_bytes = sw ? {c[7:0], c[15:8]} : c;
	endfunction

	sacop_in_t    pin_now;
	sacop_in_t    sync1_reg;
	sacop_in_t    sync2_reg;
	sacop_in_t    prev_reg;
	sacop_state_t state_reg;
	sacop_state_t state_next;
	logic [`SACOP_CNT_W-1:0] cnt_reg;
	logic [`SACOP_CNT_W-1:0] cnt_next;
	logic [RW-1:0] code_reg;
	logic [RW-1:0] code_next;
	logic [RW-1:0] result_reg;
	logic [RW-1:0] result_next;
	logic [RW-1:0] shift_reg;
	logic [RW-1:0] shift_next;
	logic          busy_reg;
	logic          busy_next;
	sacop_pins_t   pins_reg;
	sacop_pins_t   pins_next;
	logic          start_evt;
	logic          sclk_rise;
	logic          cs_fall;
	logic          out_en;
	logic          rst_pin;
	logic          read_hold;
	logic          fifo_in_valid;
	logic          fifo_in_ready;
	logic          fifo_out_valid;
	logic          load_now;
	logic [RW-1:0] fifo_out_data;

	// pins gathered; lines 9 and 11 double as serial inputs
	always_comb begin
		pin_now.cnv_n   = conversion_start_n;
		pin_now.cs_n    = device_select_n;
		pin_now.rd_n    = read_strobe_n;
		pin_now.rst_pin = reset_request;
		pin_now.pd      = power_down_request;
		pin_now.ser     = serial_parallel_select;
		pin_now.ob      = output_format_select;
		pin_now.swap    = byte_order_swap;
		pin_now.serial_chain_input    = parallel_data_bits_in[`SACOP_SERIAL_CHAIN_INPUT_BIT];
		pin_now.sclk    = parallel_data_bits_in[`SACOP_SCLK_BIT];
	end

	// two-stage synchroniser, then a third stage for edge detection
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= sacop_in_t'(`SACOP_IN_IDLE);
			sync2_reg <= sacop_in_t'(`SACOP_IN_IDLE);
			prev_reg  <= sacop_in_t'(`SACOP_IN_IDLE);
		end else begin
			sync1_reg <= pin_now;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// start edge works whatever device select shows
	assign start_evt = prev_reg.cnv_n & ~sync2_reg.cnv_n;
	// shift clock only counts while selected in serial mode
	assign sclk_rise = ~prev_reg.sclk & sync2_reg.sclk &
	                   ~sync2_reg.cs_n & sync2_reg.ser;
	assign cs_fall   = prev_reg.cs_n & ~sync2_reg.cs_n;
	assign rst_pin   = sync2_reg.rst_pin;
	// drivers on only with select and read both low, never in reset
	assign out_en    = ~sync2_reg.cs_n & ~sync2_reg.rd_n & ~rst_pin;
	// result register must not change under a read in progress
	assign read_hold = out_en | (sync2_reg.ser & ~sync2_reg.cs_n);
	assign fifo_in_valid = (state_reg == ST_PUSH) & ~rst_pin;
	assign load_now  = fifo_out_valid & ~read_hold & ~rst_pin;

	// conversion sequencer: hold, count the internal conversion time, queue
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		code_next  = code_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start_evt && !sync2_reg.pd) begin
					state_next = ST_CONV;
					cnt_next   = '0;
					code_next  = sar_code;
				end
			end
			ST_CONV: begin
				if (cnt_reg == CONV_LAST) begin
					state_next = ST_PUSH;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_PUSH: begin
				// a full queue stalls here and stretches busy
				if (fifo_in_ready) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (rst_pin) begin
			state_next = ST_IDLE;
			cnt_next   = '0;
		end
	end

	// result register, busy flag and serial shifter
	always_comb begin
		result_next = result_reg;
		shift_next  = shift_reg;
		if (load_now) begin
			result_next = fifo_out_data;
		end
		// busy covers conversion, queueing and the final load
		busy_next = ~rst_pin & ((state_next != ST_IDLE) |
		            (fifo_in_valid & fifo_in_ready) | fifo_out_valid);
		if (cs_fall && sync2_reg.ser) begin
			shift_next = fmt_code(result_reg, sync2_reg.ob);
		end else if (sclk_rise) begin
			// chain bits trail the own result by sixteen clocks
			shift_next = {shift_reg[RW-2:0], sync2_reg.serial_chain_input};
		end
		if (rst_pin) begin
			result_next = `SACOP_RESULT_RST;
			shift_next  = `SACOP_SHIFT_RST;
		end
	end

	// pin drive; serial mode floats all but the serial output line
	always_comb begin
		pins_next.dout = '0;
		pins_next.oe_n = `SACOP_DRIVE_NONE_N;
		if (sync2_reg.ser) begin
			pins_next.dout[`SACOP_SERIAL_RESULT_OUTPUT_BIT] = shift_reg[RW-1];
			if (out_en) begin
				pins_next.oe_n = ~`SACOP_SER_DRIVE_MASK;
			end
		end else begin
			pins_next.dout = swap_bytes(fmt_code(result_reg, sync2_reg.ob),
			                            sync2_reg.swap);
			if (out_en) begin
				pins_next.oe_n = `SACOP_DRIVE_ALL_N;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg  <= ST_IDLE;
			cnt_reg    <= '0;
			code_reg   <= `SACOP_RESULT_RST;
			result_reg <= `SACOP_RESULT_RST;
			shift_reg  <= `SACOP_SHIFT_RST;
			busy_reg   <= 1'b0;
			pins_reg   <= '{dout: '0, oe_n: `SACOP_DRIVE_NONE_N};
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			code_reg   <= code_next;
			result_reg <= result_next;
			shift_reg  <= shift_next;
			busy_reg   <= busy_next;
			pins_reg   <= pins_next;
		end
	end

	// finished codes queue here so a slow reader only stretches busy
	sacop_fifo #(
		.W     (RW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.flush     (rst_pin),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (code_reg),
		.out_valid (fifo_out_valid),
		.out_ready (load_now),
		.out_data  (fifo_out_data)
	);

	assign parallel_data_bits_drv = pins_reg;
	assign busy         = busy_reg;
	assign sampler_hold = (state_reg != ST_IDLE);
	assign powered_down = sync2_reg.pd;

	// checks on the port behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence conv_begin_s;
		state_reg == ST_IDLE && start_evt && !sync2_reg.pd && !rst_pin;
	endsequence

	sequence conv_busy_s;
		busy && sampler_hold && state_reg == ST_CONV;
	endsequence

	conv_start_a: assert property (
		conv_begin_s |=> conv_busy_s ##1 (state_reg == ST_CONV))
		else $error("start edge did not begin a conversion");

	conv_length_a: assert property (
		(state_reg == ST_CONV && cnt_reg == CONV_LAST && !rst_pin)
		|=> (state_reg == ST_PUSH && busy))
		else $error("conversion time not kept");

	pd_ignore_a: assert property (
		(state_reg == ST_IDLE && start_evt && sync2_reg.pd && !rst_pin)
		|=> (state_reg == ST_IDLE))
		else $error("start taken while powered down");

	reset_abort_a: assert property (
		rst_pin |=> (state_reg == ST_IDLE && !busy &&
		parallel_data_bits_drv.oe_n == `SACOP_DRIVE_NONE_N))
		else $error("reset did not abort and float the bus");

	drive_gate_a: assert property (
		!out_en |=> (parallel_data_bits_drv.oe_n == `SACOP_DRIVE_NONE_N))
		else $error("drivers on without select and read");

	serial_float_a: assert property (
		(out_en && sync2_reg.ser)
		|=> (parallel_data_bits_drv.oe_n == ~`SACOP_SER_DRIVE_MASK))
		else $error("serial mode drove an unused line");

	parallel_word_a: assert property (
		(out_en && !sync2_reg.ser) |=>
		(parallel_data_bits_drv.oe_n == `SACOP_DRIVE_ALL_N &&
		parallel_data_bits_drv.dout == swap_bytes(fmt_code(
		$past(result_reg), $past(sync2_reg.ob)), $past(sync2_reg.swap))))
		else $error("parallel word wrong");

	shift_step_a: assert property (
		(sclk_rise && !cs_fall && !rst_pin) |=>
		(shift_reg == {$past(shift_reg[RW-2:0]), $past(sync2_reg.serial_chain_input)}))
		else $error("serial shift step wrong");

	sclk_gate_a: assert property (
		(sync2_reg.cs_n && !rst_pin) |=> $stable(shift_reg))
		else $error("shift clock acted while deselected");

	result_hold_a: assert property (
		(!load_now && !rst_pin) |=> $stable(result_reg))
		else $error("result changed without a new conversion");

	busy_fall_a: assert property (
		$fell(busy) && !$past(rst_pin) |->
		!fifo_out_valid && $past(state_reg) != ST_CONV)
		else $error("busy fell before the result was loaded");
endmodule
`default_nettype wire

// ==== bench/sacop_host.sv ====
// host model: drives the converter pins and reads results back
`timescale 1ns/100ps
`default_nettype none
module sacop_host (
	input  wire logic                   sys_clk,    // system clock
	input  wire sacop_pkg::sacop_pins_t pins,       // device line drive
	input  wire logic                   busy,       // device busy
	output logic                        start_n,    // conversion start
	output logic                        cs_n,       // device select
	output logic                        rd_n,       // read strobe
	output logic                        rst_pin,    // reset pin level
	output logic                        pwr_dn,     // power down level
	output logic                        serial_sel, // 1 serial port
	output logic                        fmt_sel,    // 1 offset binary
	output logic                        swap_sel,   // 1 byte swap
	output logic [15:0]                 code,       // core code
	output logic [15:0]                 pin_in      // resolved lines
);
	import sacop_pkg::*;
	logic shift_clk;
	logic chain_in;
	logic flt;

	// idle levels from time zero, set through the tasks the tests use
	initial begin
		start_n   = 1'b1;
		shift_clk = 1'b0;
		chain_in  = 1'b0;
		flt       = 1'b0;
		code      = 16'h0000;
		sel(1'b1, 1'b1);
		cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
	end

	// undriven lines toggle so a stale value never looks valid
	always @(posedge sys_clk) flt <= ~flt;

	// wire resolution: device drive first, host drives 9 and 11 in serial
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pin_in[i] = !pins.oe_n[i] ? pins.dout[i] : flt;
		end
		if (serial_sel) begin
			pin_in[9]  = chain_in;
			pin_in[11] = shift_clk;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic cfg(input logic s, f, w, p, r);
		serial_sel <= s;
		fmt_sel    <= f;
		swap_sel   <= w;
		pwr_dn     <= p;
		rst_pin    <= r;
		tick(3);
	endtask

	task automatic sel(input logic c, r);
		cs_n <= c;
		rd_n <= r;
	endtask

	// falling start edge, held long enough to pass the synchroniser
	task automatic start(input logic [15:0] c);
		code    <= c;
		start_n <= 1'b0;
		tick(3);
		start_n <= 1'b1;
		tick(3);
	endtask

	task automatic wait_done(output logic fell);
		logic seen;
		seen = 1'b0;
		fell = 1'b0;
		for (int i = 0; i < 150 && !fell; i++) begin
			tick(1);
			if (busy === 1'b1) seen = 1'b1;
			else if (seen) fell = 1'b1;
		end
	endtask

	task automatic par_read(input logic r, output logic [15:0] d, oe);
		sel(1'b0, r);
		tick(5);
		// resolved lines: a disabled driver shows the toggling float value
		d  = pin_in;
		oe = pins.oe_n;
		sel(1'b1, 1'b1);
		tick(5);
	endtask

	// 400 ns shift clock, sampled at each fall, select held around it
	task automatic ser_read(input int n, input logic [15:0] chain,
		output logic [31:0] q, output logic [15:0] oe);
		q = 32'h0;
		shift_clk <= 1'b1; // stray pulse while deselected
		tick(3);
		shift_clk <= 1'b0;
		tick(3);
		sel(1'b0, 1'b0);
		tick(4);
		oe = pins.oe_n;
		for (int k = 1; k <= n; k++) begin
			if (k <= 16) chain_in <= chain[16-k];
			tick(1);
			shift_clk <= 1'b1;
			tick(2);
			shift_clk <= 1'b0;
			q = {q[30:0], pin_in[10]};
			tick(5);
		end
		sel(1'b1, 1'b1);
		tick(4);
	endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench of the sar converter output port
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import sacop_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_n   = 1'b0;
	int          miscompares  = 0;
	int          total_checks = 0;
	sacop_pins_t pins;
	logic        busy, hold, pdn, fell;
	logic        start_n, cs_n, rd_n, rst_pin, pwr_dn;
	logic        serial_sel, fmt_sel, swap_sel;
	logic [15:0] code, pin_in, d, oe;
	logic [31:0] q;

	always #25 sys_clk = ~sys_clk;

	sacop_top i_dut (
		.sys_clk(sys_clk), .rst_n(rst_n),
		.conversion_start_n(start_n), .device_select_n(cs_n),
		.read_strobe_n(rd_n), .reset_request(rst_pin),
		.power_down_request(pwr_dn), .serial_parallel_select(serial_sel),
		.output_format_select(fmt_sel), .byte_order_swap(swap_sel),
		.parallel_data_bits_in(pin_in), .parallel_data_bits_drv(pins),
		.sar_code(code), .busy(busy), .sampler_hold(hold),
		.powered_down(pdn)
	);

	sacop_host i_host (
		.sys_clk(sys_clk), .pins(pins), .busy(busy), .start_n(start_n),
		.cs_n(cs_n), .rd_n(rd_n), .rst_pin(rst_pin), .pwr_dn(pwr_dn),
		.serial_sel(serial_sel), .fmt_sel(fmt_sel), .swap_sel(swap_sel),
		.code(code), .pin_in(pin_in)
	);

	// expected bus word: msb flip for two's complement, then byte swap
	function automatic logic [15:0] expv(logic [15:0] r, logic f, logic s);
		logic [15:0] v;
		v = f ? r : r ^ 16'h8000;
		return s ? {v[7:0], v[15:8]} : v;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// watchdog: the whole sequence needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		i_host.tick(3);
		check("oe_n at reset", 32'(pins.oe_n), 32'hffff);
		check("busy at reset", 32'(busy), 32'h0);
		// start while the device is selected: conversion still begins
		i_host.sel(1'b0, 1'b1);
		i_host.start(16'h1234);
		check("busy", 32'(busy), 32'h1);
		check("sampler hold", 32'(hold), 32'h1);
		i_host.wait_done(fell);
		check("busy fall", 32'(fell), 32'h1);
		i_host.sel(1'b1, 1'b1);
		// every format and byte order on the parallel bus
		for (int k = 0; k < 4; k++) begin
			i_host.cfg(1'b0, k[0], k[1], 1'b0, 1'b0);
			i_host.par_read(1'b0, d, oe);
			check("par data", 32'(d), 32'(expv(16'h1234, k[0], k[1])));
			check("par oe_n", 32'(oe), 32'h0);
		end
		i_host.par_read(1'b1, d, oe);
		check("oe_n strobe high", 32'(oe), 32'hffff);
		// serial port: result msb first, then the upper byte of the chained word
		for (int k = 0; k < 2; k++) begin
			i_host.cfg(1'b1, k[0], 1'b0, 1'b0, 1'b0);
			i_host.ser_read(24, 16'ha5c3, q, oe);
			check("ser data", q, {8'h0, expv(16'h1234, k[0], 1'b0), 8'ha5});
			check("ser oe_n", 32'(oe), 32'hfbff);
		end
		// a read held across a conversion keeps the old word visible
		i_host.cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		i_host.sel(1'b0, 1'b0);
		i_host.start(16'h0f0f);
		i_host.tick(80);
		check("busy held", 32'(busy), 32'h1);
		check("old word", 32'(pin_in), 32'h1234);
		i_host.sel(1'b1, 1'b1);
		i_host.wait_done(fell);
		i_host.par_read(1'b0, d, oe);
		check("new word", 32'(d), 32'h0f0f);
		// power down only after the pending word was read out
		i_host.cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		check("powered down", 32'(pdn), 32'h1);
		i_host.start(16'h5555);
		i_host.wait_done(fell);
		check("start ignored", 32'(fell), 32'h0);
		i_host.cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		i_host.par_read(1'b0, d, oe);
		check("word kept", 32'(d), 32'h0f0f);
		// reset pin in mid conversion aborts it and floats the bus
		i_host.start(16'h7777);
		i_host.cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		i_host.tick(2);
		check("busy abort", 32'(busy), 32'h0);
		i_host.par_read(1'b0, d, oe);
		check("oe_n in reset", 32'(oe), 32'hffff);
		i_host.cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		i_host.tick(80);
		i_host.par_read(1'b0, d, oe);
		check("word cleared", 32'(d), 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
